// ### rtl/pkt_pkg.sv
/*
 * Package for the panel key, encoder and tone unit: timing counts, widths,
 * key codes and the request/answer structs shared by the unit's files.
 * Assumes a single 100 MHz system clock.
 */
package pkt_pkg;

    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_MS         = 10;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned MELODY_MS       = 30;
    localparam int unsigned MELODY_TICKS    = MELODY_MS / TICK_MS;
    localparam int unsigned TONE_PRESCALE   = 16;
    localparam int unsigned TONE_CNT_W      = 16;
    localparam int unsigned TICKS_PER_US    = CLK_HZ / 1_000_000 / TONE_PRESCALE;
    localparam int unsigned KEY_NUM         = 5;
    localparam int unsigned KEY_HIST_W      = 4;
    localparam logic [3:0]  KEY_PRESS_PAT   = 4'h8;
    localparam int unsigned KEY_FIFO_DEPTH  = 8;
    localparam int unsigned ENC_CNT_W       = 16;
    localparam int unsigned NOTE_W          = 8;
    localparam int unsigned SONG_AW         = 6;
    localparam logic [15:0] RST_ZERO16      = 16'h0000;

    typedef logic [2:0] pkt_key_code_t;

    typedef struct packed {
        logic          valid;
        pkt_key_code_t code;
    } pkt_key_ans_t;

    typedef struct packed {
        logic                  load;
        logic [SONG_AW-1:0]    addr;
        logic [NOTE_W-1:0]     note;
    } pkt_song_wr_t;

    typedef enum logic [1:0] {
        MEL_IDLE = 2'b00,
        MEL_READ = 2'b01,
        MEL_PLAY = 2'b10
    } pkt_mel_state_t;

endpackage

// ### rtl/pkt_mem.sv
/*
 * Small synchronous memory for the melody note list.
 * Assumes one clock; read data come out of a register one cycle after addr.
 */
`timescale 1ns/1ns
module pkt_mem #(
    parameter int unsigned AW = 6,
    parameter int unsigned DW = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem_ff [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_ff[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem_ff[raddr];
    end
endmodule

// ### rtl/pkt_unit.sv
/*
 * Panel key, rotary encoder and tone unit: debounced five-key FIFO, signed
 * encoder counter, 10 ms tick, tone divider and note sequencer.
 * Assumes pins are asynchronous and each passes two flip-flops first.
 */
// Functional notes
// - Four buttons and the encoder switch form five keys with own codes.
// - Each scan tick shifts every key pin level into its history.
// - A press is history high, low, low, low, oldest first.
// - Presses queue their code; key_pending shows a non-empty queue.
// - A pop returns the oldest code; an empty pop waits for a press.
// - With ENC_DIR clear, on channel A edges differing levels count up, equal down.
// - Channel B edges raise and clear a flag, never change the count.
// - Count can be peeked or taken and cleared in one access.
// - A down counter gives a tick every 10 ms driving background work.
// - Tone timer is clock divided by 16 into a 16-bit counter.
// - Tone period in microseconds becomes prescaled ticks; output toggles.
// - Zero period disconnects the tone output.
// - Sequencer plays a zero-terminated note list, stepping every 30 ms.
`timescale 1ns/1ns
module pkt_unit
    import pkt_pkg::*;
#(
    parameter int unsigned TICK_LEN = pkt_pkg::TICK_CYCLES,
    parameter bit          ENC_DIR  = 1'b0
) (
    input  wire logic                              clk,
    input  wire logic                              rstn,
    input  wire logic [pkt_pkg::KEY_NUM-1:0]       key_input_port,
    input  wire logic                              encoder_a_input,
    input  wire logic                              encoder_b_input,
    input  wire logic                              key_pop,
    output pkt_pkg::pkt_key_ans_t                  key_ans,
    output logic                                   key_pending,
    input  wire logic                              rotary_take,
    output logic signed [pkt_pkg::ENC_CNT_W-1:0]   rotary_count,
    output logic                                   enc_b_event,
    output logic                                   tick_event,
    input  wire logic                              tone_period_set,
    input  wire logic [15:0]                       tone_period_us,
    output logic                                   tone_out,
    output logic                                   tone_en,
    input  wire pkt_pkg::pkt_song_wr_t             song_wr,
    input  wire logic                              melody_begin,
    output logic                                   melody_busy
);
    import pkt_pkg::*;

    function automatic logic [15:0] us_to_ticks(input logic [15:0] us);
        logic [31:0] t;
        t = 32'(us) * 32'(TICKS_PER_US);
        us_to_ticks = (t > 32'h0000FFFF) ? 16'hFFFF : t[15:0];
    endfunction

    // Two-flop synchronisers
    logic [KEY_NUM+1:0] s1_ff, s2_ff;
    always_ff @(posedge clk) begin
        s1_ff <= {encoder_b_input, encoder_a_input, key_input_port};
        s2_ff <= s1_ff;
    end
    wire logic [KEY_NUM-1:0] keys = s2_ff[KEY_NUM-1:0];
    wire logic               enc_a = s2_ff[KEY_NUM];
    wire logic               enc_b = s2_ff[KEY_NUM+1];

    // 10 ms tick
    logic [31:0] tick_cnt_ff;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tick_cnt_ff <= 32'(TICK_LEN - 1);
            tick_event  <= 1'b0;
        end else if (tick_cnt_ff == 32'h0) begin
            tick_cnt_ff <= 32'(TICK_LEN - 1);
            tick_event  <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff - 32'h1;
            tick_event  <= 1'b0;                // Flag cleared on the next cycle
        end
    end

    // Key history and press detect, bit 3 oldest
    logic [KEY_HIST_W-1:0] hist_ff [KEY_NUM];
    logic [KEY_NUM-1:0]    press_ff;
    always_ff @(posedge clk) begin
        for (int i = 0; i < KEY_NUM; i++) begin
            if (!rstn) begin
                hist_ff[i]  <= 4'h0;
                press_ff[i] <= 1'b0;
            end else if (tick_event) begin
                hist_ff[i]  <= {hist_ff[i][2:0], keys[i]};
                press_ff[i] <= ({hist_ff[i][2:0], keys[i]} == KEY_PRESS_PAT);
            end else begin
                press_ff[i] <= 1'b0;
            end
        end
    end

    // Key FIFO; presses of several keys on one tick queue one per cycle
    logic [KEY_NUM-1:0] pend_ff;
    logic [2:0]         wr_idx_ff, rd_idx_ff;
    logic [3:0]         fill_ff;
    logic               pop_wait_ff;
    logic [2:0]         key_q_ff [KEY_FIFO_DEPTH];
    logic               push;
    pkt_key_code_t      push_code;
    logic               do_pop;
    logic               do_push;

    always_comb begin
        push      = 1'b0;
        push_code = 3'h0;
        for (int i = KEY_NUM - 1; i >= 0; i--) begin
            if (pend_ff[i]) begin
                push      = 1'b1;
                push_code = 3'(i);              // Key code is the key index
            end
        end
    end

    assign do_pop = (key_pop || pop_wait_ff) && (fill_ff != 4'h0);
    // Full queue: the new code is dropped
    assign do_push = push && (fill_ff != 4'(KEY_FIFO_DEPTH));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= (pend_ff & ~(KEY_NUM'(push) << push_code)) | press_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            key_q_ff[wr_idx_ff] <= push_code;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_idx_ff   <= 3'h0;
            rd_idx_ff   <= 3'h0;
            fill_ff     <= 4'h0;
            pop_wait_ff <= 1'b0;
            key_ans     <= '0;
            key_pending <= 1'b0;
        end else begin
            if (do_push) begin
                wr_idx_ff <= wr_idx_ff + 3'h1;
            end
            if (do_pop) begin
                rd_idx_ff <= rd_idx_ff + 3'h1;
            end
            fill_ff     <= fill_ff + 4'(do_push) - 4'(do_pop);
            key_pending <= (fill_ff + 4'(do_push) - 4'(do_pop)) != 4'h0;
            // An empty pop is held until a code arrives
            pop_wait_ff <= (key_pop || pop_wait_ff) && !do_pop;
            key_ans.valid <= do_pop;
            // Code holds between pops so a late reader still sees the last one
            if (do_pop) begin
                key_ans.code <= key_q_ff[rd_idx_ff];
            end
        end
    end

    // Rotary encoder
    logic enc_a_d_ff, enc_b_d_ff;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            enc_a_d_ff   <= 1'b0;
            enc_b_d_ff   <= 1'b0;
            enc_b_event  <= 1'b0;
            rotary_count <= '0;
        end else begin
            enc_a_d_ff  <= enc_a;
            enc_b_d_ff  <= enc_b;
            enc_b_event <= enc_b ^ enc_b_d_ff;  // Pulse, self-clearing
            // A take on the same cycle as a step keeps the step
            if (enc_a ^ enc_a_d_ff) begin
                if ((enc_a != enc_b) ^ ENC_DIR) begin
                    rotary_count <= (rotary_take ? '0 : rotary_count) + 16'sd1;
                end else begin
                    rotary_count <= (rotary_take ? '0 : rotary_count) - 16'sd1;
                end
            end else if (rotary_take) begin
                rotary_count <= '0;             // Read-and-clear; peek is the port
            end
        end
    end

    // Tone generator
    logic [3:0]  pre_ff;
    logic [15:0] tone_cnt_ff, tone_ticks_ff;
    logic        mel_set;
    logic [15:0] mel_period;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pre_ff        <= 4'h0;
            tone_cnt_ff   <= RST_ZERO16;
            tone_ticks_ff <= RST_ZERO16;
            tone_en       <= 1'b0;
            tone_out      <= 1'b0;
        end else begin
            pre_ff <= pre_ff + 4'h1;            // Divide by 16
            if (tone_period_set || mel_set) begin
                tone_ticks_ff <= us_to_ticks(mel_set ? mel_period : tone_period_us);
                tone_en       <= (mel_set ? mel_period : tone_period_us) != 16'h0;
                tone_cnt_ff   <= RST_ZERO16;
                tone_out      <= 1'b0;
            end else if (!tone_en) begin
                tone_out <= 1'b0;               // Pin detached from compare
            end else if (pre_ff == 4'hF) begin
                if (tone_cnt_ff + 16'h1 >= tone_ticks_ff) begin
                    tone_cnt_ff <= RST_ZERO16;
                    tone_out    <= ~tone_out;   // Compare fires each interval
                end else begin
                    tone_cnt_ff <= tone_cnt_ff + 16'h1;
                end
            end
        end
    end

    // Note sequencer; note: [7:4] pitch index, [3:0] duration in 30 ms steps
    logic [SONG_AW-1:0] mel_addr_ff;
    logic [SONG_AW-1:0] nxt_mel_addr;
    logic [NOTE_W-1:0]  note_rd;
    logic [3:0]         dur_ff;
    logic [1:0]         sub_ff;
    pkt_mel_state_t     mel_st_ff;

    pkt_mem #(.AW(SONG_AW), .DW(NOTE_W)) u_song (
        .clk   (clk),
        .we    (song_wr.load),
        .waddr (song_wr.addr),
        .wdata (song_wr.note),
        .raddr (nxt_mel_addr),
        .rdata (note_rd)
    );

    // Pitch index to period in microseconds; zero is a rest
    assign mel_period = (note_rd[7:4] == 4'h0) ? 16'h0 : 16'(16'h1000 >> note_rd[7:5]) +
                        16'(note_rd[4] ? 16'h0100 : 16'h0000);
    assign mel_set    = (mel_st_ff == MEL_READ) && (note_rd != 8'h00);
    // Read data lag the address by a cycle, so the address leads the state by one step
    assign nxt_mel_addr = (mel_st_ff == MEL_IDLE && melody_begin) ? '0 :
                          (mel_st_ff == MEL_PLAY && tick_event && dur_ff <= 4'h1 &&
                           sub_ff == 2'(MELODY_TICKS - 1)) ? mel_addr_ff + SONG_AW'(1) :
                          mel_addr_ff;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mel_st_ff   <= MEL_IDLE;
            mel_addr_ff <= '0;
            dur_ff      <= 4'h0;
            sub_ff      <= 2'h0;
            melody_busy <= 1'b0;
        end else begin
            case (mel_st_ff)
                MEL_IDLE: begin
                    if (melody_begin) begin
                        mel_addr_ff <= '0;
                        mel_st_ff   <= MEL_READ;
                        melody_busy <= 1'b1;
                    end
                end
                MEL_READ: begin
                    if (note_rd == 8'h00) begin   // Terminator ends the list
                        mel_st_ff   <= MEL_IDLE;
                        melody_busy <= 1'b0;
                    end else begin
                        dur_ff    <= note_rd[3:0];
                        sub_ff    <= 2'h0;
                        mel_st_ff <= MEL_PLAY;
                    end
                end
                MEL_PLAY: begin
                    if (tick_event) begin
                        if (sub_ff == 2'(MELODY_TICKS - 1)) begin   // 30 ms step
                            sub_ff <= 2'h0;
                            if (dur_ff <= 4'h1) begin
                                mel_addr_ff <= nxt_mel_addr;
                                mel_st_ff   <= MEL_READ;
                            end else begin
                                dur_ff <= dur_ff - 4'h1;
                            end
                        end else begin
                            sub_ff <= sub_ff + 2'h1;
                        end
                    end
                end
                default: mel_st_ff <= MEL_IDLE;
            endcase
        end
    end
endmodule

// ### test/pkt_chk.sv
/* Assertions on the ports of pkt_unit.
   Bound to pkt_unit from tb_top; TICK_LEN is handed on by the bind. */
`timescale 1ns/1ns
module pkt_chk
    import pkt_pkg::*;
#(
    parameter int unsigned TICK_LEN = pkt_pkg::TICK_CYCLES
) (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  key_pop,
    input wire pkt_pkg::pkt_key_ans_t key_ans,
    input wire logic                  key_pending,
    input wire logic                  rotary_take,
    input wire logic signed [15:0]    rotary_count,
    input wire logic                  enc_b_event,
    input wire logic                  tick_event,
    input wire logic                  tone_period_set,
    input wire logic [15:0]           tone_period_us,
    input wire logic                  tone_out,
    input wire logic                  tone_en,
    input wire logic                  melody_begin,
    input wire logic                  melody_busy
);
    int unsigned gap_ff;
    logic        seen_ff;
    // The first gap after reset has no reference tick, so seen_ff masks it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gap_ff  <= 0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff  <= tick_event ? 0 : gap_ff + 1;
            seen_ff <= seen_ff | tick_event;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence tone_req;
        tone_period_set && tone_period_us != 16'h0000 && !melody_busy;
    endsequence
    sequence tone_fresh;
        (tone_en && !tone_out) [*8];
    endsequence
    tick_gap_a: assert property (tick_event && seen_ff |-> gap_ff == TICK_LEN - 1)
        else $error("tick spacing wrong");
    tick_pulse_a: assert property (tick_event |=> !tick_event)
        else $error("tick longer than one cycle");
    press_on_tick_a: assert property ($rose(key_pending) |-> seen_ff && gap_ff <= 4)
        else $error("key queued away from a tick");
    pop_answer_a: assert property (key_pop && key_pending |=> key_ans.valid)
        else $error("pop not answered");
    count_step_a: assert property ($changed(rotary_count) && !$past(rotary_take)
        |-> rotary_count - $past(rotary_count) inside {1, -1})
        else $error("count moved by more than one");
    b_edge_still_a: assert property (enc_b_event |-> $stable(rotary_count) ##1 $stable(rotary_count))
        else $error("channel B moved the count");
    take_zero_a: assert property (rotary_take |=> rotary_count inside {-1, 0, 1})
        else $error("take did not clear");
    tone_off_a: assert property (tone_period_set && tone_period_us == 16'h0000 && !melody_busy
        |=> !tone_en && !tone_out)
        else $error("zero period left tone on");
    tone_on_a: assert property (tone_req |=> tone_fresh)
        else $error("tone start wrong");
    tone_quiet_a: assert property (!tone_en |-> !tone_out)
        else $error("tone out while disconnected");
    melody_start_a: assert property (melody_begin && !melody_busy |=> melody_busy)
        else $error("melody did not start");
endmodule

// ### test/pkt_far.sv
/* Far side: five push buttons pulled up (low while pressed) and a two-channel
   rotary encoder. Pins change 1 ns after a rising edge of clk. */
`timescale 1ns/1ns
module pkt_far
    import pkt_pkg::*;
(
    input  wire logic                   clk,
    output logic [pkt_pkg::KEY_NUM-1:0] keys,
    output logic                        enc_a,
    output logic                        enc_b
);
    int b_edges = 0;
    initial begin
        keys  = '1;
        enc_a = 1'b0;
        enc_b = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Contact bounce shorter than one scan gap, then a steady press and release
    task automatic press(input int k, input int gap);
        int i;
        for (i = 0; i < 5; i++) begin
            keys[k] = ~keys[k];
            cyc(1);
        end
        cyc(gap * 5);
        keys[k] = 1'b1;
        cyc(gap * 5);
    endtask
    // One quadrature step; B moves first when A alone would go the wrong way
    task automatic step(input bit up);
        if ((enc_a != enc_b) == up) begin
            enc_b = ~enc_b;
            b_edges++;
            cyc(6);
        end
        enc_a = ~enc_a;
        cyc(6);
    endtask
endmodule

// ### test/tb_top.sv
/* Top bench for pkt_unit: tone table first, then keys, encoder, melody.
   Far side is pkt_far; the checker is bound at the foot of this file. */
`timescale 1ns/1ns
module tb_top;
    import pkt_pkg::*;
    localparam int unsigned TL = 20;
    typedef struct {logic [15:0] us; int half;} pkt_row_t;
    logic                  clk, rstn, key_pop, rotary_take, tone_period_set, melody_begin;
    logic [15:0]           tone_period_us;
    pkt_song_wr_t          song_wr;
    logic [KEY_NUM-1:0]    keys;
    logic                  enc_a, enc_b, key_pending, enc_b_event, tick_event;
    logic                  tone_out, tone_en, melody_busy;
    pkt_key_ans_t          key_ans;
    logic signed [15:0]    rotary_count;
    int                    n_mismatch = 0;
    int                    check_count = 0;
    int                    i, n;
    int                    b_seen = 0;
    pkt_row_t rows [4] = '{'{16'h0001, 96}, '{16'h0003, 288}, '{16'h0000, 0}, '{16'h000A, 960}};
    pkt_unit #(.TICK_LEN(TL), .ENC_DIR(1'b0)) pkt_unit_i (
        .clk(clk), .rstn(rstn), .key_input_port(keys), .encoder_a_input(enc_a),
        .encoder_b_input(enc_b), .key_pop(key_pop), .key_ans(key_ans),
        .key_pending(key_pending), .rotary_take(rotary_take), .rotary_count(rotary_count),
        .enc_b_event(enc_b_event), .tick_event(tick_event), .tone_period_set(tone_period_set),
        .tone_period_us(tone_period_us), .tone_out(tone_out), .tone_en(tone_en),
        .song_wr(song_wr), .melody_begin(melody_begin), .melody_busy(melody_busy));
    pkt_far pkt_far_i (.clk(clk), .keys(keys), .enc_a(enc_a), .enc_b(enc_b));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) if (enc_b_event === 1'b1) b_seen++;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic pop(input pkt_key_code_t exp);
        int k;
        tick(1);
        key_pop = 1'b1;
        tick(1);
        key_pop = 1'b0;
        for (k = 0; k < 4000 && key_ans.valid !== 1'b1; k++) tick(1);
        cmp({key_ans.valid, key_ans.code}, {1'b1, exp});
    endtask
    task automatic set_tone(input logic [15:0] us);
        tone_period_us  = us;
        tone_period_set = 1'b1;
        tick(1);
        tone_period_set = 1'b0;
    endtask
    task automatic conclude;
        $display("mismatches %0d of %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(30_000 * 10);
        n_mismatch++;
        conclude();
    end
    initial begin
        rstn = 1'b0;
        {key_pop, rotary_take, tone_period_set, melody_begin} = 4'h0;
        tone_period_us = 16'h0000;
        song_wr = '0;
        tick(20);
        rstn = 1'b1;
        tick(1);
        cmp({key_pending, tone_en, melody_busy, rotary_count}, 0);
        // Each row: connect or cut the tone, then time one high phase
        foreach (rows[r]) begin
            set_tone(rows[r].us);
            tick(1);
            cmp({tone_en, tone_out}, {rows[r].half != 0, 1'b0});
            if (rows[r].half != 0) begin
                for (n = 0; n < 3000 && tone_out !== 1'b1; n++) tick(1);
                for (n = 0; n < 3000 && tone_out === 1'b1; n++) tick(1);
                cmp(n, rows[r].half);
            end
        end
        for (i = 0; i < KEY_NUM; i++) pkt_far_i.press(i, TL);
        cmp(key_pending, 1);
        for (i = 0; i < KEY_NUM; i++) pop(i[2:0]);
        cmp(key_pending, 0);
        // Nine presses into eight places: the ninth is lost
        for (i = 0; i < 9; i++) pkt_far_i.press(i % 5, TL);
        for (i = 0; i < 8; i++) pop(3'(i % 5));
        cmp(key_pending, 0);
        fork pop(3'h3); pkt_far_i.press(3, TL); join
        // Three steps up, five down, then take
        for (i = 0; i < 8; i++) pkt_far_i.step(i < 3);
        cmp({rotary_count}, 16'hFFFE);
        cmp(b_seen, pkt_far_i.b_edges);
        cmp({rotary_count}, 16'hFFFE);
        rotary_take = 1'b1;
        tick(1);
        rotary_take = 1'b0;
        tick(1);
        cmp({rotary_count}, 16'h0000);
        // One note of pitch 1 lasting two steps, then the end mark
        song_wr = '{load: 1'b1, addr: 6'h00, note: 8'h12};
        tick(1);
        song_wr = '{load: 1'b1, addr: 6'h01, note: 8'h00};
        tick(1);
        song_wr = '0;
        melody_begin = 1'b1;
        tick(1);
        melody_begin = 1'b0;
        cmp(melody_busy, 1);
        tick(3);
        cmp(tone_en, 1);
        for (n = 0; n < 400 && melody_busy === 1'b1; n++) tick(1);
        cmp(n >= 5 * TL && n <= 6 * TL, 1);
        // Reset after the melody ends, with the last note still sounding, clears every output
        rstn = 1'b0;
        tick(2);
        cmp({key_pending, tone_en, tone_out, melody_busy, rotary_count}, 0);
        rstn = 1'b1;
        tick(2);
        conclude();
    end
endmodule
bind pkt_unit pkt_chk #(.TICK_LEN(TICK_LEN)) pkt_chk_i (
    .clk(clk), .rstn(rstn), .key_pop(key_pop), .key_ans(key_ans), .key_pending(key_pending),
    .rotary_take(rotary_take), .rotary_count(rotary_count), .enc_b_event(enc_b_event),
    .tick_event(tick_event), .tone_period_set(tone_period_set),
    .tone_period_us(tone_period_us), .tone_out(tone_out), .tone_en(tone_en),
    .melody_begin(melody_begin), .melody_busy(melody_busy));
